//--- core/odsb_top.sv
// Object dictionary, settings store and status bank of the instrument.
`timescale 1ns/1ps
module odsb_top #(
  parameter int FLAG_W = 32
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_obj_req,
  input wire logic i_obj_write,
  input wire logic [15:0] i_obj_index,
  input wire logic [31:0] i_obj_wdata,
  input wire logic [31:0] i_meas_current,
  input wire logic [31:0] i_meas_voltage,
  input wire logic [31:0] i_meas_power,
  input wire logic [FLAG_W-1:0] i_cond_flags,
  output logic o_obj_ack,
  output logic [31:0] o_obj_rdata,
  output logic [1:0] o_obj_err,
  output logic o_defaults_reload,
  output logic o_output_on,
  output logic o_locked,
  output logic [1:0] o_reg_mode,
  output logic [31:0] o_active_target,
  output logic [31:0] o_rise_slew,
  output logic [31:0] o_fall_slew
);
  // -----------------------------------------------------------
  // Storage and decode signals
  // -----------------------------------------------------------
  logic [31:0] set_r [odsb_pkg::NSLOT];
  logic wr_hit;
  logic rd_hit;
  logic [4:0] wr_slot;
  logic [4:0] rd_slot;
  logic in_mfr;
  logic ro_hit;
  logic locked;
  logic guarded;
  logic set_we;
  logic restore_we;
  logic [1:0] err_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0] mode_sel;
  logic [1:0] run_cnt_r;

  odsb_status_if st_if ();

  function automatic logic [5:0] find_slot(input logic [15:0] idx, input logic rd);
    logic [5:0] res;
    res = 6'h00;
    for (int k = 0; k < odsb_pkg::NSLOT; k++) begin
      if (idx == (rd ? odsb_pkg::RD_IDX[k] : odsb_pkg::WR_IDX[k])) begin
        res = {1'b1, 5'(k)};
      end
    end
    return res;
  endfunction

  // -----------------------------------------------------------
  // Status path
  // -----------------------------------------------------------
  odsb_sync #(
    .W(FLAG_W)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_d(i_cond_flags),
    .o_q(st_if.raw_flags)
  );

  assign st_if.live = set_r[odsb_pkg::SLOT_OUTPUT][0];

  odsb_status u_status (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .st(st_if.status)
  );

  // -----------------------------------------------------------
  // Request decode
  // -----------------------------------------------------------
  always_comb begin
    {wr_hit, wr_slot} = find_slot(i_obj_index, 1'b0);
    {rd_hit, rd_slot} = find_slot(i_obj_index, 1'b1);
    in_mfr = (i_obj_index >= odsb_pkg::MFR_BEGIN) && (i_obj_index <= odsb_pkg::MFR_END);
    ro_hit = rd_hit || (i_obj_index inside {odsb_pkg::IDX_QUES, odsb_pkg::IDX_OPER,
      odsb_pkg::IDX_MEAS_CUR, odsb_pkg::IDX_MEAS_VOLT, odsb_pkg::IDX_MEAS_PWR});
    locked = set_r[odsb_pkg::SLOT_LOCK][0];
    // Start and stop, and the lock itself, stay reachable while locked.
    guarded = locked && (wr_slot != odsb_pkg::SLOT_LOCK) && (wr_slot != odsb_pkg::SLOT_OUTPUT);
    set_we = 1'b0;
    restore_we = 1'b0;
    err_nxt = odsb_pkg::ERR_NONE;
    rdata_nxt = '0;
    if (!in_mfr) begin
      err_nxt = odsb_pkg::ERR_NOOBJ;
    end else if (i_obj_write) begin
      if (wr_hit) begin
        if (guarded) begin
          err_nxt = odsb_pkg::ERR_LOCKED;
        end else begin
          set_we = i_obj_req;
        end
      end else if (i_obj_index == odsb_pkg::IDX_RESTORE) begin
        if (locked) begin
          err_nxt = odsb_pkg::ERR_LOCKED;
        end else begin
          restore_we = i_obj_req;
        end
      end else if (ro_hit) begin
        err_nxt = odsb_pkg::ERR_ACCESS;
      end else begin
        err_nxt = odsb_pkg::ERR_NOOBJ;
      end
    end else if (rd_hit) begin
      rdata_nxt = set_r[rd_slot];
    end else begin
      case (i_obj_index)
        odsb_pkg::IDX_QUES: rdata_nxt = st_if.ques_word;
        odsb_pkg::IDX_OPER: rdata_nxt = st_if.op_word;
        odsb_pkg::IDX_MEAS_CUR: rdata_nxt = i_meas_current;
        odsb_pkg::IDX_MEAS_VOLT: rdata_nxt = i_meas_voltage;
        odsb_pkg::IDX_MEAS_PWR: rdata_nxt = i_meas_power;
        odsb_pkg::IDX_RESTORE: err_nxt = odsb_pkg::ERR_ACCESS;
        default: err_nxt = wr_hit ? odsb_pkg::ERR_ACCESS : odsb_pkg::ERR_NOOBJ;
      endcase
    end
  end

  // An unknown mode code falls back to voltage regulation rather than none.
  always_comb begin
    mode_sel = set_r[odsb_pkg::SLOT_MODE][1:0];
    if (mode_sel == odsb_pkg::MODE_ILLEGAL) begin
      mode_sel = odsb_pkg::MODE_VOLTAGE;
    end
  end

  // -----------------------------------------------------------
  // Settings store
  // -----------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int k = 0; k < odsb_pkg::NSLOT; k++) begin
        set_r[k] <= odsb_pkg::SETTING_RST;
      end
    end else if (i_ce) begin
      if (restore_we) begin
        for (int k = 0; k < odsb_pkg::NSLOT; k++) begin
          if (5'(k) != odsb_pkg::SLOT_LOCK) begin
            set_r[k] <= odsb_pkg::SETTING_RST;
          end
        end
      end else if (set_we) begin
        set_r[wr_slot] <= i_obj_wdata;
      end
    end
  end

  // -----------------------------------------------------------
  // Answer
  // -----------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_obj_ack <= 1'b0;
      o_obj_rdata <= '0;
      o_obj_err <= odsb_pkg::ERR_NONE;
      o_defaults_reload <= 1'b0;
    end else if (i_ce) begin
      o_obj_ack <= i_obj_req;
      o_defaults_reload <= restore_we;
      if (i_obj_req) begin
        o_obj_rdata <= rdata_nxt;
        o_obj_err <= err_nxt;
      end
    end
  end

  // -----------------------------------------------------------
  // Settings that steer the regulator
  // -----------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_output_on <= 1'b0;
      o_locked <= 1'b0;
      o_reg_mode <= '0;
      o_active_target <= '0;
      o_rise_slew <= '0;
      o_fall_slew <= '0;
    end else if (i_ce) begin
      o_output_on <= set_r[odsb_pkg::SLOT_OUTPUT][0];
      o_locked <= locked;
      o_reg_mode <= mode_sel;
      o_active_target <= set_r[odsb_pkg::SLOT_TARGET + 5'(mode_sel)];
      o_rise_slew <= set_r[odsb_pkg::SLOT_RISE + 5'(mode_sel)];
      o_fall_slew <= set_r[odsb_pkg::SLOT_FALL + 5'(mode_sel)];
    end
  end

  // -----------------------------------------------------------
  // Checks
  // -----------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !i_ce) begin
      run_cnt_r <= 2'h0;
    end else if (run_cnt_r != 2'h3) begin
      run_cnt_r <= run_cnt_r + 2'h1;
    end
  end

  sequence s_wr_current;
    i_ce && i_obj_req && i_obj_write && (i_obj_index == 16'h2201) && !locked;
  endsequence

  sequence s_rd_current;
    i_ce && i_obj_req && !i_obj_write && (i_obj_index == 16'h2202);
  endsequence

  property p_pair_readback;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      s_wr_current ##3 s_rd_current |=> o_obj_rdata == $past(i_obj_wdata, 4);
  endproperty
  a_pair_readback: assert property (p_pair_readback) else $error("readback mismatch");

  property p_reserved;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && (i_obj_index >= 16'hc000 || i_obj_index < 16'h1000)
      |=> o_obj_ack && o_obj_err == odsb_pkg::ERR_NOOBJ;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved index answered");

  property p_meas_ro;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && i_obj_write && (i_obj_index == 16'h2101)
      |=> o_obj_err == odsb_pkg::ERR_ACCESS;
  endproperty
  a_meas_ro: assert property (p_meas_ro) else $error("measurement written");

  property p_locked;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && i_obj_write && locked && (i_obj_index == 16'h2203)
      |=> $stable(set_r[2]) && o_obj_err == odsb_pkg::ERR_LOCKED;
  endproperty
  a_locked: assert property (p_locked) else $error("locked change taken");

  property p_restore;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && i_obj_write && !locked && (i_obj_index == 16'h2701)
      |=> o_defaults_reload && set_r[1] == odsb_pkg::SETTING_RST ##1 !o_defaults_reload;
  endproperty
  a_restore: assert property (p_restore) else $error("restore not done");

  property p_restore_noread;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && !i_obj_write && (i_obj_index == 16'h2701)
      |=> o_obj_err == odsb_pkg::ERR_ACCESS;
  endproperty
  a_restore_noread: assert property (p_restore_noread) else $error("restore read");

  property p_status_no_side;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && !i_obj_write && (i_obj_index == 16'h200d)
      |=> $stable(set_r[0]) && $stable(set_r[15]);
  endproperty
  a_status_no_side: assert property (p_status_no_side) else $error("status read side effect");

  property p_unlatched;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      run_cnt_r == 2'h3 |->
      (st_if.op_word & odsb_pkg::STATUS_COND_MASK)
      == ($past(i_cond_flags, 3) & odsb_pkg::STATUS_COND_MASK);
  endproperty
  a_unlatched: assert property (p_unlatched) else $error("status not live");

  property p_status_ro;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && i_obj_write && (i_obj_index inside {16'h200b, 16'h200d})
      |=> o_obj_err == odsb_pkg::ERR_ACCESS;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status word written");

  property p_meas_live;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && !i_obj_write && (i_obj_index == 16'h2102)
      |=> o_obj_rdata == $past(i_meas_voltage);
  endproperty
  a_meas_live: assert property (p_meas_live) else $error("measurement not live");

  property p_status_read;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && !i_obj_write && (i_obj_index == 16'h200d)
      |=> o_obj_rdata == $past(st_if.op_word);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_ques_read;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && !i_obj_write && (i_obj_index == 16'h200b)
      |=> o_obj_rdata == $past(st_if.ques_word);
  endproperty
  a_ques_read: assert property (p_ques_read) else $error("questionable read wrong");

  property p_profile_areas;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && ((i_obj_index inside {[16'h1000:16'h1fff]})
      || (i_obj_index inside {[16'h6000:16'h9fff]}))
      |=> o_obj_err == odsb_pkg::ERR_NOOBJ;
  endproperty
  a_profile_areas: assert property (p_profile_areas) else $error("profile area answered");

  property p_lock_write;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && i_obj_write && (i_obj_index == 16'h2703)
      |=> set_r[odsb_pkg::SLOT_LOCK] == $past(i_obj_wdata)
      && o_obj_err == odsb_pkg::ERR_NONE;
  endproperty
  a_lock_write: assert property (p_lock_write) else $error("lock write lost");

  property p_mode_fallback;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && (set_r[odsb_pkg::SLOT_MODE][1:0] == odsb_pkg::MODE_ILLEGAL)
      |=> o_reg_mode == odsb_pkg::MODE_VOLTAGE;
  endproperty
  a_mode_fallback: assert property (p_mode_fallback) else $error("illegal mode shown");

  property p_current_slews;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && (set_r[odsb_pkg::SLOT_MODE][1:0] == 2'h0)
      |=> o_rise_slew == $past(set_r[8]) && o_fall_slew == $past(set_r[11]);
  endproperty
  a_current_slews: assert property (p_current_slews) else $error("wrong slew pair");

  property p_restore_locked;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_ce && i_obj_req && i_obj_write && locked && (i_obj_index == 16'h2701)
      |=> !o_defaults_reload && o_obj_err == odsb_pkg::ERR_LOCKED;
  endproperty
  a_restore_locked: assert property (p_restore_locked) else $error("locked restore taken");

  property p_live_bit;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      st_if.op_word[odsb_pkg::BIT_LIVE] == o_output_on;
  endproperty
  a_live_bit: assert property (p_live_bit) else $error("live bit disagrees");
endmodule // odsb_top

//--- pkg/odsb_pkg.sv
// Constants of the object dictionary and status bank.
package odsb_pkg;
  localparam int DATA_W = 32;
  localparam int IDX_W = 16;
  // -----------------------------------------------------------
  // Index map
  // -----------------------------------------------------------
  localparam logic [15:0] IDX_QUES = 16'h200b;
  localparam logic [15:0] IDX_OPER = 16'h200d;
  localparam logic [15:0] IDX_MEAS_CUR = 16'h2101;
  localparam logic [15:0] IDX_MEAS_VOLT = 16'h2102;
  localparam logic [15:0] IDX_MEAS_PWR = 16'h2103;
  localparam logic [15:0] IDX_RESTORE = 16'h2701;
  localparam logic [15:0] MFR_BEGIN = 16'h2000;
  localparam logic [15:0] MFR_END = 16'h5fff;
  localparam int NSLOT = 19;
  localparam logic [4:0] SLOT_OUTPUT = 5'h00;
  localparam logic [4:0] SLOT_TARGET = 5'h01;
  localparam logic [4:0] SLOT_RISE = 5'h08;
  localparam logic [4:0] SLOT_FALL = 5'h0b;
  localparam logic [4:0] SLOT_MODE = 5'h0e;
  localparam logic [4:0] SLOT_LOCK = 5'h0f;
  localparam logic [15:0] WR_IDX [NSLOT] = '{16'h200f, 16'h2201, 16'h2203, 16'h2205,
    16'h2301, 16'h2303, 16'h2305, 16'h2307, 16'h2401, 16'h2403, 16'h2405, 16'h2409,
    16'h240b, 16'h240d, 16'h2503, 16'h2703, 16'h2706, 16'h2708, 16'h270a};
  localparam logic [15:0] RD_IDX [NSLOT] = '{16'h2010, 16'h2202, 16'h2204, 16'h2206,
    16'h2302, 16'h2304, 16'h2306, 16'h2308, 16'h2402, 16'h2404, 16'h2406, 16'h240a,
    16'h240c, 16'h240e, 16'h2504, 16'h2702, 16'h2707, 16'h2709, 16'h270b};
  localparam logic [31:0] SETTING_RST = 32'h0000_0000;
  // -----------------------------------------------------------
  // Modes and answers
  // -----------------------------------------------------------
  localparam logic [1:0] MODE_VOLTAGE = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL = 2'h3;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_NOOBJ = 2'h1;
  localparam logic [1:0] ERR_ACCESS = 2'h2;
  localparam logic [1:0] ERR_LOCKED = 2'h3;
  // -----------------------------------------------------------
  // Status word layout
  // -----------------------------------------------------------
  localparam int BIT_STANDBY = 0;
  localparam int BIT_LIVE = 1;
  localparam logic [31:0] STATUS_ASSIGNED = 32'h7fdf_fff3;
  localparam logic [31:0] STATUS_COND_MASK = 32'h7fdf_fff0;
  localparam logic [31:0] QUES_MASK = 32'h0003_01f0;
  localparam logic [31:0] STATUS_RST = 32'h0000_0001;
endpackage

//--- pkg/odsb_status_if.sv
// Carrier between the condition synchroniser and the status assembler.
`timescale 1ns/1ps
interface odsb_status_if;
  logic [31:0] raw_flags;
  logic live;
  logic [31:0] op_word;
  logic [31:0] ques_word;
  modport src (output raw_flags, output live, input op_word, input ques_word);
  modport status (input raw_flags, input live, output op_word, output ques_word);
endinterface

//--- core/odsb_sync.sv
// Two-stage synchroniser for the condition pins.
`timescale 1ns/1ps
module odsb_sync #(
  parameter int W = 32
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second; nothing else may look at it.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      meta_r <= '0;
      o_q <= '0;
    end else if (i_ce) begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule // odsb_sync

//--- core/odsb_status.sv
// Assembler of the live operation and questionable status words.
`timescale 1ns/1ps
module odsb_status (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  odsb_status_if.status st
);
  logic [31:0] op_nxt;

  always_comb begin
    op_nxt = st.raw_flags & odsb_pkg::STATUS_COND_MASK;
    op_nxt[odsb_pkg::BIT_STANDBY] = ~st.live;
    op_nxt[odsb_pkg::BIT_LIVE] = st.live;
  end

  // Words follow the conditions every enabled cycle; nothing is held or cleared by reads.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st.op_word <= odsb_pkg::STATUS_RST;
      st.ques_word <= '0;
    end else if (i_ce) begin
      st.op_word <= op_nxt;
      st.ques_word <= op_nxt & odsb_pkg::QUES_MASK;
    end
  end

  property p_standby_live;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      st.op_word[odsb_pkg::BIT_STANDBY] != st.op_word[odsb_pkg::BIT_LIVE];
  endproperty
  a_standby_live: assert property (p_standby_live) else $error("standby and live agree");

  property p_avail_zero;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (st.op_word & ~odsb_pkg::STATUS_ASSIGNED) == 32'h0;
  endproperty
  a_avail_zero: assert property (p_avail_zero) else $error("available bit set");

  property p_ques_subset;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      st.ques_word == (st.op_word & odsb_pkg::QUES_MASK);
  endproperty
  a_ques_subset: assert property (p_ques_subset) else $error("questionable not subset");
endmodule // odsb_status

//--- testbench/odsb_master_model.sv
// Fieldbus master model that issues one object access at a time.
`timescale 1ns/1ps
module odsb_master_model (
  input wire logic i_core_clk,
  input wire logic i_ack,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_err,
  output logic o_req,
  output logic o_write,
  output logic [15:0] o_index,
  output logic [31:0] o_wdata
);
  // ----------------------------------------------------------------
  // Access task
  // ----------------------------------------------------------------
  initial begin
    o_req = 1'b0;
    o_write = 1'b0;
    o_index = 16'h0000;
    o_wdata = 32'h0000_0000;
  end

  // One cycle is one access, so the request drops right after the taking edge.
  // Index and data are inverted when idle so stale values are never mistaken for a request.
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic [1:0] er, output logic ok);
    int n;
    @(posedge i_core_clk);
    o_req <= 1'b1;
    o_write <= wr;
    o_index <= idx;
    o_wdata <= wd;
    @(posedge i_core_clk);
    o_req <= 1'b0;
    o_index <= ~idx;
    o_wdata <= ~wd;
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      // The answer is taken at the edge that samples ack high, before that edge clears it.
      @(posedge i_core_clk);
      ok = (i_ack === 1'b1);
    end
    rd = i_rdata;
    er = i_err;
  endtask
endmodule // odsb_master_model

//--- testbench/odsb_top_test.sv
// Self-checking bench for the object dictionary and status bank.
`timescale 1ns/1ps
module odsb_top_test;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic req;
  logic wr;
  logic [15:0] idx;
  logic [31:0] wd;
  logic [31:0] cur = 32'h3f80_0011;
  logic [31:0] volt = 32'h4120_0022;
  logic [31:0] pwr = 32'h42c8_0033;
  logic [31:0] flags = 32'h0000_0000;
  logic ce = 1'b1;
  logic ack;
  logic reload;
  logic on;
  logic locked;
  logic [1:0] err;
  logic [1:0] mode;
  logic [31:0] rdata;
  logic [31:0] tgt;
  logic [31:0] rise;
  logic [31:0] fall;
  logic [31:0] rd;
  logic [1:0] er;
  logic ok;
  int fail_count = 0;
  int n_checks = 0;

  always #4 i_core_clk = ~i_core_clk;

  odsb_top #(.FLAG_W(32)) uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_ce(ce),
    .i_obj_req(req), .i_obj_write(wr), .i_obj_index(idx), .i_obj_wdata(wd),
    .i_meas_current(cur), .i_meas_voltage(volt), .i_meas_power(pwr), .i_cond_flags(flags),
    .o_obj_ack(ack), .o_obj_rdata(rdata), .o_obj_err(err), .o_defaults_reload(reload),
    .o_output_on(on), .o_locked(locked), .o_reg_mode(mode), .o_active_target(tgt),
    .o_rise_slew(rise), .o_fall_slew(fall));

  odsb_master_model master (.i_core_clk(i_core_clk), .i_ack(ack), .i_rdata(rdata),
    .i_err(err), .o_req(req), .o_write(wr), .o_index(idx), .o_wdata(wd));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d,
                     input logic [1:0] e);
    master.xfer(w, i, d, rd, er, ok);
    check({31'h0, ok}, 32'h1);
    check({30'h0, er}, {30'h0, e});
  endtask

  // Bit 0 is kept clear so the lock and output objects stay off during the sweep.
  function automatic logic [31:0] dat(input int k);
    return {16'ha5c3, odsb_pkg::WR_IDX[k]} & 32'hffff_fffe;
  endfunction

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin : main
    int k;
    int m;
    logic [15:0] bad [11] = '{16'h0000, 16'h00a0, 16'h0fff, 16'h1000, 16'h1fff, 16'h6000,
      16'h9fff, 16'hc000, 16'hffff, 16'h2000, 16'h5fff};
    logic [31:0] pats [3] = '{32'hffff_ffff, 32'h8020_000f, 32'h0002_4150};
    logic [31:0] expo [3] = '{32'h7fdf_fff1, 32'h0000_0001, 32'h0002_4151};
    logic [31:0] expq [3] = '{32'h0003_01f0, 32'h0000_0000, 32'h0002_0150};
    repeat (3) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_core_clk);
    #1;
    check({26'h0, ack, on, locked, reload, mode}, 32'h0);
    check(tgt | rise | fall, 32'h0);
    acc(1'b0, 16'h200d, 32'h0, 2'h0);
    check(rd, 32'h0000_0001);
    for (k = 0; k < odsb_pkg::NSLOT; k++) begin
      acc(1'b0, odsb_pkg::RD_IDX[k], 32'h0, 2'h0);
      check(rd, 32'h0);
      acc(1'b1, odsb_pkg::WR_IDX[k], dat(k), 2'h0);
      acc(1'b0, odsb_pkg::RD_IDX[k], 32'h0, 2'h0);
      check(rd, dat(k));
      acc(1'b1, odsb_pkg::RD_IDX[k], ~dat(k), 2'h2);
      acc(1'b0, odsb_pkg::WR_IDX[k], 32'h0, 2'h2);
    end
    for (k = 0; k < 4; k++) begin
      m = (k == 3) ? 1 : k;
      acc(1'b1, 16'h2503, k[31:0], 2'h0);
      acc(1'b0, 16'h2504, 32'h0, 2'h0);
      check(rd, k[31:0]);
      check({30'h0, mode}, m[31:0]);
      check(tgt, dat(int'(odsb_pkg::SLOT_TARGET) + m));
      check(rise, dat(int'(odsb_pkg::SLOT_RISE) + m));
      check(fall, dat(int'(odsb_pkg::SLOT_FALL) + m));
    end
    // A request made while the clock enable is low must be lost and change nothing.
    @(posedge i_core_clk);
    ce <= 1'b0;
    master.xfer(1'b1, 16'h2201, 32'h0, rd, er, ok);
    check({31'h0, ok}, 32'h0);
    ce <= 1'b1;
    acc(1'b0, 16'h2202, 32'h0, 2'h0);
    check(rd, dat(1));
    acc(1'b0, 16'h2101, 32'h0, 2'h0);
    check(rd, 32'h3f80_0011);
    acc(1'b0, 16'h2102, 32'h0, 2'h0);
    check(rd, 32'h4120_0022);
    acc(1'b0, 16'h2103, 32'h0, 2'h0);
    check(rd, 32'h42c8_0033);
    acc(1'b1, 16'h2102, 32'h1, 2'h2);
    acc(1'b1, 16'h2101, 32'h1, 2'h2);
    for (k = 0; k < 11; k++) begin
      acc(1'b0, bad[k], 32'h0, 2'h1);
      acc(1'b1, bad[k], 32'h0, 2'h1);
    end
    for (k = 0; k < 3; k++) begin
      @(posedge i_core_clk);
      flags <= pats[k];
      repeat (3) @(posedge i_core_clk);
      acc(1'b0, 16'h200d, 32'h0, 2'h0);
      check(rd, expo[k]);
      acc(1'b0, 16'h200d, 32'h0, 2'h0);
      check(rd, expo[k]);
      acc(1'b0, 16'h200b, 32'h0, 2'h0);
      check(rd, expq[k]);
    end
    acc(1'b1, 16'h200d, 32'hffff_ffff, 2'h2);
    acc(1'b1, 16'h200b, 32'hffff_ffff, 2'h2);
    acc(1'b1, 16'h200f, 32'h1, 2'h0);
    acc(1'b0, 16'h200d, 32'h0, 2'h0);
    check(rd, 32'h0002_4152);
    check({31'h0, on}, 32'h1);
    acc(1'b1, 16'h2703, 32'h1, 2'h0);
    @(posedge i_core_clk);
    check({31'h0, locked}, 32'h1);
    acc(1'b1, 16'h2201, 32'h1234_5678, 2'h3);
    acc(1'b1, 16'h2203, 32'h0, 2'h3);
    acc(1'b1, 16'h2503, 32'h0, 2'h3);
    acc(1'b0, 16'h2202, 32'h0, 2'h0);
    check(rd, dat(1));
    acc(1'b1, 16'h2701, 32'h1, 2'h3);
    check({31'h0, reload}, 32'h0);
    acc(1'b1, 16'h200f, 32'h0, 2'h0);
    acc(1'b1, 16'h2703, 32'h2, 2'h0);
    acc(1'b1, 16'h2701, 32'h1, 2'h0);
    check({31'h0, reload}, 32'h1);
    acc(1'b0, 16'h2202, 32'h0, 2'h0);
    check(rd, 32'h0);
    acc(1'b0, 16'h2702, 32'h0, 2'h0);
    check(rd, 32'h2);
    acc(1'b0, 16'h2701, 32'h0, 2'h2);
    end_of_test();
  end
endmodule // odsb_top_test
